// ---- logic/tsj_top.sv ----
// Tether safety junction supervisor with APB register access
//
// Functional notes
// R1: Power lamp green when powered and ready
// R2: Lit-stop lamp green for lit-button terminal
// R3: Network lamp follows Ethernet link
// R4: Solid green bar for healthy terminal
// R5: Solid white bar with bridge plug
// R6: Blinking white bar with nothing attached
// R7: Removal starts 10 s countdown, yellow
// R8: One segment off per 1.67 s
// R9: Countdown expiry enters safe mode, blinking yellow
// R10: Pressed stop gives safe mode, solid red
// R11: Bar driven only while powered
// R12: Power loss opens the stop relays
// R13: Snapshot stored at power-down, reloaded after
// R14: Stored stop with released button is error
// R15: Error clears after press then unlock
// R16: Normal, bridge, stop and error states kept
// R17: Removal detected, timer allows 10 s
// R18: Stop input bypassed during timer state
// R19: Lit button recognised and illuminated
// R20: Lit recognition needs configuration switch
// R21: Pressed button released before normal returns
// R22: Bridge in time, else stop triggered
// R23: Safe mode opens relay outputs
// R24: Timers from prescaled tick, synchronous clear
// R25: Inputs synchronised and debounced
`timescale 1ns/100ps
module tsj_top
  import tsj_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire tsj_pins_t   pins,
  input  wire logic        power_good,
  input  wire tsj_snap_t   nv_rd,
  output logic             nv_wr_en,
  output tsj_snap_t        nv_wr,
  output tsj_lamps_t       lamps,
  output tsj_color_t       bar_color,
  output logic [NSEG-1:0]  bar_seg,
  output logic             relay_close,
  output logic             button_lamp
);

  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned NIN = 6;

  logic [9:0]      sync1_reg;
  logic [9:0]      sync2_reg;
  tsj_pins_t       raw_pins;
  logic            pg;
  tsj_snap_t       nv_in;
  tsj_pins_t       deb;
  logic [PW-1:0]   pre_reg;
  logic            tick_reg;
  logic            pg_prev_reg;
  tsj_state_t      state_reg;
  logic [TW-1:0]   disc_reg;
  logic [TW-1:0]   seg_sub_reg;
  logic [2:0]      seg_lit_reg;
  logic            armed_reg;
  tsj_snap_t       snap_reg;
  logic [TW-1:0]   blink_cnt_reg;
  logic            blink_reg;
  logic            ctrl_reg;
  logic [NSEG-1:0] seg_mask;
  logic            stop_active;
  logic            lit_ok;
  logic            apb_wr;
  tsj_status_t     status_word;

  // R25: two-stage synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 10'h000;
      sync2_reg <= 10'h000;
    end
    else
    begin
      sync1_reg <= {pins, power_good, nv_rd};
      sync2_reg <= sync1_reg;
    end
  end

  assign raw_pins = sync2_reg[9:4];
  assign pg       = sync2_reg[3];
  assign nv_in    = sync2_reg[2:0];

  // R24: prescaled tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (pre_reg == PW'(TICK_CYCLES - 1))
    begin
      pre_reg  <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      pre_reg  <= pre_reg + PW'(1);
      tick_reg <= 1'b0;
    end
  end

  // R25: per-input debounce, value accepted after stable ticks
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_deb
      logic [1:0] cnt_reg;
      logic       val_reg;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cnt_reg <= 2'h0;
          val_reg <= 1'b0;
        end
        else if (raw_pins[gi] == val_reg)
          cnt_reg <= 2'h0;
        else if (tick_reg)
        begin
          if (cnt_reg == 2'(DEB_TICKS - 1))
          begin
            val_reg <= raw_pins[gi];
            cnt_reg <= 2'h0;
          end
          else
            cnt_reg <= cnt_reg + 2'h1;
        end
      end
      assign deb[gi] = val_reg;
    end
  endgenerate

  // Blink phase shared by blinking bar patterns
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end
    else if (tick_reg)
    begin
      if (blink_cnt_reg == TW'(BLINK_TICKS - 1))
      begin
        blink_cnt_reg <= '0;
        blink_reg     <= ~blink_reg;
      end
      else
        blink_cnt_reg <= blink_cnt_reg + TW'(1);
    end
  end

  assign stop_active = (state_reg == ST_ESTOP) || (state_reg == ST_SAFE)
                       || (state_reg == ST_ERROR);
  // R20: lit button counts only with the switch set
  assign lit_ok = deb.term && deb.lit_btn && deb.lit_cfg;

  // Supervisor state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg   <= ST_OFF;
      disc_reg    <= '0;
      seg_sub_reg <= '0;
      seg_lit_reg <= 3'h0;
      armed_reg   <= 1'b0;
      snap_reg    <= '0;
    end
    // R24: synchronous clear while power is absent
    else if (!pg)
    begin
      state_reg   <= ST_OFF;
      disc_reg    <= '0;
      seg_sub_reg <= '0;
      seg_lit_reg <= 3'h0;
      armed_reg   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_OFF:
        begin
          state_reg <= ST_START;
          disc_reg  <= '0;
          // R13: reload retained snapshot
          snap_reg  <= nv_in;
        end
        ST_START:
        begin
          if (tick_reg)
            disc_reg <= disc_reg + TW'(1);
          if (disc_reg == TW'(START_TICKS))
          begin
            // R14: stored stop but button released
            if (snap_reg.stop && deb.term && !deb.estop)
            begin
              state_reg <= ST_ERROR;
              armed_reg <= 1'b0;
            end
            else if (deb.bridge)
              state_reg <= ST_BRIDGE;
            else if (deb.term && (deb.estop || snap_reg.stop))
              state_reg <= ST_ESTOP;
            else if (deb.term)
              state_reg <= ST_NORMAL;
            else
              state_reg <= ST_EMPTY;
          end
        end
        ST_EMPTY:
        begin
          if (deb.bridge)
            state_reg <= ST_BRIDGE;
          else if (deb.term && deb.estop)
            state_reg <= ST_ESTOP;
          else if (deb.term)
            state_reg <= ST_NORMAL;
        end
        ST_NORMAL, ST_BRIDGE:
        begin
          // R10: pressed button trips the stop
          if (state_reg == ST_NORMAL && deb.term && deb.estop)
            state_reg <= ST_ESTOP;
          else if (ctrl_reg)
            state_reg <= ST_SAFE;
          // R17: removal starts the reconnect timer
          else if ((state_reg == ST_NORMAL && !deb.term)
                   || (state_reg == ST_BRIDGE && !deb.bridge))
          begin
            state_reg   <= ST_TIMER;
            disc_reg    <= '0;
            seg_sub_reg <= '0;
            seg_lit_reg <= SEG_FULL;
          end
          // R16: bridge plug taken over from normal unless stop, force-safe or removal applies first
          else if (deb.bridge)
            state_reg <= ST_BRIDGE;
        end
        ST_TIMER:
        begin
          // R22: bridge accepted within the window
          if (deb.bridge)
            state_reg <= ST_BRIDGE;
          // R18: stop input ignored until a released terminal
          else if (deb.term && !deb.estop)
            state_reg <= ST_NORMAL;
          else if (ctrl_reg)
            state_reg <= ST_SAFE;
          else if (tick_reg)
          begin
            disc_reg <= disc_reg + TW'(1);
            // R8: step one segment off per period
            if (seg_sub_reg == TW'(SEG_TICKS - 1))
            begin
              seg_sub_reg <= '0;
              if (seg_lit_reg != 3'h0)
                seg_lit_reg <= seg_lit_reg - 3'h1;
            end
            else
              seg_sub_reg <= seg_sub_reg + TW'(1);
            // R9: expiry enters safe mode
            if (disc_reg == TW'(DISC_TICKS - 1))
            begin
              state_reg   <= ST_SAFE;
              seg_lit_reg <= 3'h0;
            end
          end
        end
        ST_SAFE:
        begin
          if (!ctrl_reg && deb.bridge)
            state_reg <= ST_BRIDGE;
          else if (!ctrl_reg && deb.term && !deb.estop)
            state_reg <= ST_NORMAL;
        end
        ST_ESTOP:
        begin
          // R21: released button before normal
          if (deb.term && !deb.estop && !ctrl_reg)
            state_reg <= ST_NORMAL;
          else if (!deb.term)
          begin
            state_reg   <= ST_TIMER;
            disc_reg    <= '0;
            seg_sub_reg <= '0;
            seg_lit_reg <= SEG_FULL;
          end
        end
        ST_ERROR:
        begin
          // R15: press then unlock clears error
          if (deb.term && deb.estop)
            armed_reg <= 1'b1;
          else if (armed_reg && deb.term && !deb.estop)
          begin
            state_reg <= ST_NORMAL;
            armed_reg <= 1'b0;
          end
        end
        default:
          state_reg <= ST_OFF;
      endcase
    end
  end

  // Lit segments fill from the left, right end goes dark first
  generate
    for (gi = 0; gi < NSEG; gi++)
    begin : g_seg
      assign seg_mask[gi] = ({1'b0, seg_lit_reg} + 4'(gi)) >= 4'(NSEG);
    end
  endgenerate

  // Retained snapshot write at power-down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pg_prev_reg <= 1'b0;
      nv_wr_en    <= 1'b0;
      nv_wr       <= '0;
    end
    else
    begin
      pg_prev_reg <= pg;
      nv_wr_en    <= 1'b0;
      // R13: store inputs and stop state
      if (pg_prev_reg && !pg && state_reg != ST_OFF && state_reg != ST_START)
      begin
        nv_wr_en <= 1'b1;
        nv_wr    <= {stop_active, deb.bridge, deb.term};
      end
    end
  end

  // Relay, lamps and status bar
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay_close <= 1'b0;
      lamps       <= '0;
      button_lamp <= 1'b0;
      bar_color   <= COL_OFF;
      bar_seg     <= '0;
    end
    else
    begin
      // R12: relays open on power loss; R23: open in safe mode
      relay_close <= pg && ((state_reg == ST_NORMAL) || (state_reg == ST_BRIDGE)
                            || (state_reg == ST_TIMER));
      // R1: ready once startup has finished
      lamps.pwr   <= pg && (state_reg != ST_OFF) && (state_reg != ST_START);
      // R2: lit-stop lamp
      lamps.lit   <= pg && lit_ok;
      // R3: network lamp
      lamps.eth   <= pg && deb.eth;
      // R19: drive the button illumination
      button_lamp <= pg && lit_ok && (state_reg != ST_OFF);
      bar_color   <= COL_OFF;
      bar_seg     <= '0;
      // R11: bar only while the power lamp is lit
      if (lamps.pwr && pg)
      begin
        case (state_reg)
          // R4: solid green
          ST_NORMAL:
          begin
            bar_color <= COL_GREEN;
            bar_seg   <= '1;
          end
          // R5: solid white
          ST_BRIDGE:
          begin
            bar_color <= COL_WHITE;
            bar_seg   <= '1;
          end
          // R6: blinking white
          ST_EMPTY:
          begin
            bar_color <= COL_WHITE;
            bar_seg   <= {NSEG{blink_reg}};
          end
          // R7: yellow countdown
          ST_TIMER:
          begin
            bar_color <= COL_YELLOW;
            bar_seg   <= seg_mask;
          end
          // R9: blinking yellow
          ST_SAFE:
          begin
            bar_color <= COL_YELLOW;
            bar_seg   <= {NSEG{blink_reg}};
          end
          // R10: solid red
          ST_ESTOP:
          begin
            bar_color <= COL_RED;
            bar_seg   <= '1;
          end
          ST_ERROR:
          begin
            bar_color <= COL_RED;
            bar_seg   <= {NSEG{blink_reg}};
          end
          default:
          begin
            bar_color <= COL_OFF;
            bar_seg   <= '0;
          end
        endcase
      end
    end
  end

  // Status word assembly
  always_comb
  begin
    status_word        = '0;
    status_word.relay  = relay_close;
    status_word.pwr    = lamps.pwr;
    status_word.pins   = deb;
    status_word.seg    = bar_seg;
    status_word.color  = bar_color;
    status_word.state  = state_reg;
  end

  assign apb_wr = psel && penable && pready && pwrite;

  // Control register, force-safe request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= CTRL_RST;
    else if (apb_wr && paddr == REG_CTRL)
      ctrl_reg <= pwdata[0];
  end

  // APB slave, one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (paddr == REG_CTRL)
        prdata <= {31'h0000_0000, ctrl_reg};
      else if (paddr == REG_STATUS)
        prdata <= status_word;
      else if (paddr == REG_TIMER)
        prdata <= {22'h00_0000, disc_reg};
      else if (paddr == REG_STORE)
        prdata <= {29'h0000_0000, snap_reg};
      else
        pslverr <= 1'b1;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ---- logic/tsj_pkg.sv ----
// Shared constants, types and register layout for the tether safety junction controller
package tsj_pkg;

  // Clock and prescaled tick
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_MS     = 10;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000 * TICK_MS;

  // Times in their own unit and derived tick counts
  localparam int unsigned DISC_MS     = 10_000;
  localparam int unsigned SEG_MS      = 1_670;
  localparam int unsigned BLINK_MS    = 500;
  localparam int unsigned DEB_MS      = 20;
  localparam int unsigned DISC_TICKS  = DISC_MS / TICK_MS;
  localparam int unsigned SEG_TICKS   = SEG_MS / TICK_MS;
  localparam int unsigned BLINK_TICKS = BLINK_MS / TICK_MS;
  localparam int unsigned DEB_TICKS   = DEB_MS / TICK_MS;
  localparam int unsigned START_TICKS = DEB_TICKS + 1;

  // Counter width, segment count and full segment value
  localparam int unsigned TW          = 10;
  localparam int unsigned NSEG        = 6;
  localparam logic [2:0]  SEG_FULL    = 3'h6;

  // Register byte addresses and reset values
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_TIMER   = 8'h08;
  localparam logic [7:0]  REG_STORE   = 8'h0C;
  localparam logic        CTRL_RST    = 1'b0;

  // Supervisor states
  typedef enum logic [3:0] {
    ST_OFF    = 4'h0,
    ST_START  = 4'h1,
    ST_EMPTY  = 4'h2,
    ST_NORMAL = 4'h3,
    ST_BRIDGE = 4'h4,
    ST_ESTOP  = 4'h5,
    ST_TIMER  = 4'h6,
    ST_SAFE   = 4'h7,
    ST_ERROR  = 4'h8
  } tsj_state_t;

  // Status bar colours
  typedef enum logic [2:0] {
    COL_OFF    = 3'h0,
    COL_GREEN  = 3'h1,
    COL_WHITE  = 3'h2,
    COL_YELLOW = 3'h3,
    COL_RED    = 3'h4
  } tsj_color_t;

  // Pin inputs from the plug and box
  typedef struct packed {
    logic term;
    logic bridge;
    logic estop;
    logic lit_btn;
    logic lit_cfg;
    logic eth;
  } tsj_pins_t;

  // Indicator lamps
  typedef struct packed {
    logic pwr;
    logic lit;
    logic eth;
  } tsj_lamps_t;

  // Retained snapshot
  typedef struct packed {
    logic stop;
    logic bridge;
    logic term;
  } tsj_snap_t;

  // Status register layout
  typedef struct packed {
    logic [5:0] rsv_hi;
    logic       relay;
    logic       pwr;
    logic [1:0] rsv_b;
    tsj_pins_t  pins;
    logic [1:0] rsv_c;
    logic [5:0] seg;
    logic       rsv_d;
    tsj_color_t color;
    logic [3:0] state;
  } tsj_status_t;

endpackage

// ---- bench/tsj_monitor.sv ----
// Port checker for the tether safety junction controller
`timescale 1ns/100ps
module tsj_monitor
  import tsj_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 8
)
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire tsj_pins_t       pins,
  input wire logic            power_good,
  input wire logic            nv_wr_en,
  input wire tsj_lamps_t      lamps,
  input wire tsj_color_t      bar_color,
  input wire logic [NSEG-1:0] bar_seg,
  input wire logic            relay_close
);
  logic [7:0] eth_cnt_reg;

  // Cycles the link input has held still
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eth_cnt_reg <= 8'h00;
    else if (!$stable(pins.eth))
      eth_cnt_reg <= 8'h00;
    else if (eth_cnt_reg != 8'hFF)
      eth_cnt_reg <= eth_cnt_reg + 8'h01;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bar_needs_pwr: assert property (bar_color != COL_OFF && $past(bar_color) != COL_OFF |-> lamps.pwr)
    else $error("status bar lit without power lamp");
  a_red_opens: assert property (bar_color == COL_RED |-> !relay_close)
    else $error("red bar with relays closed");
  a_drop_opens: assert property ($fell(power_good) |-> ##[1:6] !relay_close)
    else $error("relays still closed after supply loss");
  a_nv_on_drop: assert property (nv_wr_en |-> !power_good)
    else $error("snapshot written while supply present");
  a_nv_pulse: assert property (nv_wr_en |=> !nv_wr_en)
    else $error("snapshot write longer than one cycle");
  a_lit_needs_cfg: assert property (lamps.lit |-> pins.lit_cfg)
    else $error("lit stop lamp without configuration switch");
  a_eth_follow: assert property (lamps.pwr && eth_cnt_reg >= 5 * TICK_CYCLES |-> lamps.eth == pins.eth)
    else $error("network lamp differs from link");
  // Relay closed on both cycles keeps the safe-mode blink out of the countdown check
  a_seg_step: assert property (bar_color == COL_YELLOW && relay_close && $past(relay_close)
    && bar_seg != 6'h00 && $past(bar_seg) != 6'h00
    && bar_seg != $past(bar_seg) |-> bar_seg == ($past(bar_seg) << 1))
    else $error("countdown segment not dropped from the right");
  a_green_closed: assert property (bar_color == COL_GREEN |-> relay_close)
    else $error("green bar with relays open");
  a_apb_pulse: assert property (pready |=> !pready && !pslverr)
    else $error("bus answer longer than one cycle");

  c_countdown: cover property (bar_color == COL_YELLOW && bar_seg == 6'h3E);
  c_red: cover property (bar_color == COL_RED);
  c_snapshot: cover property (nv_wr_en);
endmodule

bind tsj_top tsj_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.pclk(pclk), .presetn(presetn),
  .pready(pready), .pslverr(pslverr), .pins(pins), .power_good(power_good),
  .nv_wr_en(nv_wr_en), .lamps(lamps), .bar_color(bar_color), .bar_seg(bar_seg),
  .relay_close(relay_close));

// ---- bench/tsj_plug_model.sv ----
// Terminal and bridge plug model driving the box pin inputs
`timescale 1ns/100ps
module tsj_plug_model
  import tsj_pkg::*;
(
  input wire logic pclk,
  output tsj_pins_t pins
);
  // Nothing plugged, no link at start
  initial pins = '0;

  // Attach a terminal, a bridge plug or nothing
  task automatic plug(input logic term, input logic bridge, input logic lit);
    @(posedge pclk);
    pins.term <= term;
    pins.bridge <= bridge;
    pins.lit_btn <= lit & term;
  endtask

  // Stop button level
  task automatic press(input logic v);
    @(posedge pclk);
    pins.estop <= v;
  endtask

  // Lit button switch and link level
  task automatic set_cfg(input logic cfg, input logic eth);
    @(posedge pclk);
    pins.lit_cfg <= cfg;
    pins.eth <= eth;
  endtask

  task automatic press_unlock(input int hold);
    press(1'b1);
    repeat (hold) @(posedge pclk);
    press(1'b0);
  endtask
endmodule

// ---- bench/tsj_top_bench.sv ----
// Self-checking bench for the tether safety junction controller
`timescale 1ns/100ps
module tsj_top_bench;
  import tsj_pkg::*;
  localparam int unsigned TK = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        power_good, nv_wr_en, relay_close, button_lamp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  bar_seg;
  tsj_pins_t   pins;
  tsj_snap_t   nv_mem = '0;
  tsj_snap_t   nv_wr;
  tsj_lamps_t  lamps;
  tsj_color_t  bar_color;
  int          failures, n_tests, waited;

  // 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // Retained memory takes the snapshot pulse
  always @(posedge pclk)
    if (nv_wr_en === 1'b1)
      nv_mem <= nv_wr;

  tsj_top #(.TICK_CYCLES(TK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .power_good(power_good),
    .nv_rd(nv_mem), .nv_wr_en(nv_wr_en), .nv_wr(nv_wr), .lamps(lamps),
    .bar_color(bar_color), .bar_seg(bar_seg), .relay_close(relay_close),
    .button_lamp(button_lamp));
  tsj_plug_model plug (.pclk(pclk), .pins(pins));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One bus transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    // A bus answer that never comes counts as a mismatch
    if (pready !== 1'b1)
    begin
      failures++;
      summarize();
    end
    rd = prdata;
    check(32'(pslverr), 32'(err));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] probe(input int s);
    case (s)
      0: return 32'(bar_color);
      1: return 32'(relay_close);
      default: return 32'(bar_seg);
    endcase
  endfunction

  // Bounded wait for bar colour, relay or segments
  task automatic wait_for(input int s, input logic [31:0] v, input int lim);
    waited = 0;
    while (probe(s) !== v && waited < lim)
    begin
      @(posedge pclk);
      waited++;
    end
    check(probe(s), v);
    // Only a wait that ended without the value stops the run
    if (probe(s) !== v)
      summarize();
  endtask

  task automatic st_is(input tsj_state_t s);
    apb(1'b0, REG_STATUS, 32'h0, 1'b0);
    check(32'(rd[3:0]), 32'(s));
  endtask

  task automatic t_power_up;
    plug.set_cfg(1'b1, 1'b1);
    power_good <= 1'b1;
    wait_for(0, 32'(COL_WHITE), 80 * TK);
    check(32'(lamps.pwr), 32'h1);
    repeat (4 * TK) @(posedge pclk);
    check(32'(lamps.eth), 32'h1);
    st_is(ST_EMPTY);
  endtask

  task automatic t_attach;
    plug.plug(1'b1, 1'b0, 1'b1);
    wait_for(0, 32'(COL_GREEN), 10 * TK);
    check(32'(lamps.lit), 32'h1);
    check(32'(button_lamp), 32'h1);
    check(32'(relay_close), 32'h1);
    st_is(ST_NORMAL);
  endtask

  task automatic t_error;
    plug.press(1'b1);
    wait_for(0, 32'(COL_RED), 10 * TK);
    st_is(ST_ESTOP);
    power_good <= 1'b0;
    wait_for(1, 32'h0, 10);
    repeat (10) @(posedge pclk);
    check(32'(nv_mem), 32'h5);
    plug.press(1'b0);
    plug.set_cfg(1'b0, 1'b1);
    repeat (4 * TK) @(posedge pclk);
    power_good <= 1'b1;
    repeat ((START_TICKS + 6) * TK) @(posedge pclk);
    st_is(ST_ERROR);
    check(32'(relay_close), 32'h0);
    plug.press_unlock(4 * TK);
    wait_for(0, 32'(COL_GREEN), 20 * TK);
    st_is(ST_NORMAL);
    check(32'(lamps.lit), 32'h0);
  endtask

  task automatic t_timer;
    plug.plug(1'b0, 1'b0, 1'b0);
    wait_for(0, 32'(COL_YELLOW), 10 * TK);
    check(32'(bar_seg), 32'h3F);
    wait_for(2, 32'h3E, 200 * TK);
    check(32'(waited >= 166 * TK && waited <= 168 * TK), 32'h1);
    plug.press(1'b1);
    repeat (5 * TK) @(posedge pclk);
    check(32'(relay_close), 32'h1);
    plug.press(1'b0);
    plug.plug(1'b0, 1'b1, 1'b0);
    wait_for(0, 32'(COL_WHITE), 10 * TK);
    check(32'(relay_close), 32'h1);
    st_is(ST_BRIDGE);
  endtask

  task automatic t_expire;
    plug.plug(1'b0, 1'b0, 1'b0);
    wait_for(0, 32'(COL_YELLOW), 10 * TK);
    wait_for(1, 32'h0, 1100 * TK);
    check(32'(waited >= 998 * TK && waited <= 1001 * TK), 32'h1);
    st_is(ST_SAFE);
    wait_for(2, 32'h00, 60 * TK);
    wait_for(2, 32'h3F, 60 * TK);
    check(32'(bar_color), 32'(COL_YELLOW));
  endtask

  task automatic t_regs;
    apb(1'b1, REG_CTRL, 32'h1, 1'b0);
    apb(1'b0, REG_CTRL, 32'h0, 1'b0);
    check(rd, 32'h1);
    apb(1'b1, 8'h20, 32'h1, 1'b1);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    check(rd, 32'h0);
    // Forced safe mode holds even with the bridge plug in
    plug.plug(1'b0, 1'b1, 1'b0);
    repeat (5 * TK) @(posedge pclk);
    st_is(ST_SAFE);
    apb(1'b1, REG_CTRL, 32'h0, 1'b0);
    wait_for(0, 32'(COL_WHITE), 10 * TK);
    apb(1'b1, REG_CTRL, 32'h1, 1'b0);
    wait_for(1, 32'h0, 10 * TK);
    apb(1'b1, REG_CTRL, 32'h0, 1'b0);
    wait_for(1, 32'h1, 10 * TK);
    // Supply loss with relays closed in bridge mode
    power_good <= 1'b0;
    wait_for(1, 32'h0, 10);
    repeat (10) @(posedge pclk);
    check(32'(nv_mem), 32'h2);
  endtask

  // Reset, then the scenarios in order
  initial
  begin
    {presetn, psel, penable, pwrite, power_good} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_power_up();
    t_attach();
    t_error();
    t_timer();
    t_expire();
    t_regs();
    summarize();
  end
endmodule
